// *** core/sscs_pkg.sv ***
// constants and types for the system clock source selector
package sscs_pkg;

    // ==========================================
    // register map, byte addresses
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_SLOW_SEL = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_SLEEP_LEN = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_CAL = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================
    // field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SWITCH_BIT = 2;
    localparam int CTRL_DIV_LSB = 3;
    localparam int CTRL_SLEEP_BIT = 6;
    localparam int SLOW_SEL_LSB = 0;
    localparam int STAT_SRC_BIT = 0;
    localparam int STAT_XRDY_BIT = 1;
    localparam int STAT_SLOW_LSB = 2;
    localparam int STAT_LOCK_BIT = 4;
    localparam int STAT_RCRUN_BIT = 5;
    localparam int STAT_ASLEEP_BIT = 6;
    localparam int STAT_PEND_BIT = 7;

    // ==========================================
    // modes and encodings
    typedef enum logic [1:0] {SW_AUTO = 2'h0, SW_MANUAL = 2'h1, SW_STAY_RC = 2'h2} sscs_swmode_e;
    typedef enum logic [1:0] {SLOW_RC = 2'h0, SLOW_XTAL = 2'h1, SLOW_EXT = 2'h2} sscs_slow_e;
    typedef enum logic [2:0] {CPU_32 = 3'h0, CPU_16 = 3'h1, CPU_8 = 3'h2, CPU_4 = 3'h3, CPU_2 = 3'h4,
                              CPU_1 = 3'h5} sscs_cpudiv_e;

    // ==========================================
    // widths and reset values
    localparam int SLEEP_LEN_W = 16;
    localparam int CAL_W = 16;
    localparam int CAL_FRAC_BITS = 8;
    localparam int ACC_W = 25;
    localparam int CPU_CNT_W = 4;
    localparam logic [1:0] RST_MODE = SW_AUTO;
    localparam logic [2:0] RST_DIV = CPU_16;
    localparam logic [SLEEP_LEN_W-1:0] RST_SLEEP_LEN = 16'h0020;
    localparam logic [CAL_W-1:0] CAL_ONE = 16'h0100;

    // ==========================================
    // sampled pin indices
    localparam int PIN_XTAL = 0;
    localparam int PIN_FRC = 1;
    localparam int PIN_SRC = 2;
    localparam int PIN_SXT = 3;
    localparam int PIN_SEXT = 4;
    localparam int PIN_XRDY = 5;
    localparam int NPIN = 6;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SLOW_RC_TIMEOUT_NS = 100000;
    localparam int SLOW_RC_TIMEOUT_CYC = (SLOW_RC_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    localparam int RC_CNT_W = 16;

endpackage

// *** core/sscs_clock_select.sv ***
// system clock source selector with dividers, slow clock lock, sleep timer and register slave
// ==========================================
// Summary of operation
// - system clock enable halves the selected oscillator, crystal or fast RC
// - processor clock at 32..1 MHz selectable
// - fast RC may source system clock
// - wake from sleep on fast RC
// - auto mode moves to crystal when ready
// - manual mode waits for software request
// - stay-RC mode keeps RC until the mode changes
// - slow clock from RC, crystal or external
// - reset selects slow RC oscillator
// - other slow source locked until reset
// - slow clock times sleep length
// - calibration factor scales RC sleep timing
// - external slow clock from pin nine
module sscs_clock_select #(
    parameter int SLOW_RC_TIMEOUT_CYC = sscs_pkg::SLOW_RC_TIMEOUT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sscs_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [sscs_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic xtal_osc_clk,
    input wire logic fast_rc_clk,
    input wire logic slow_rc_clk,
    input wire logic slow_crystal_in,
    input wire logic gpio_pin_nine,
    input wire logic xtal_ready,
    output logic sys_clk_en,
    output logic cpu_clk_en,
    output logic slow_tick,
    output logic sys_src_xtal,
    output logic asleep,
    output logic wake_pulse
);

    // ==========================================
    // pin sampling
    logic [sscs_pkg::NPIN-1:0] pin_raw;
    logic [sscs_pkg::NPIN-1:0] s1_reg;
    logic [sscs_pkg::NPIN-1:0] s2_reg;
    logic [sscs_pkg::NPIN-1:0] s3_reg;
    logic [sscs_pkg::NPIN-1:0] filt_reg;
    logic [sscs_pkg::NPIN-1:0] filt_next;
    logic [sscs_pkg::NPIN-1:0] rise;

    assign pin_raw = {xtal_ready, gpio_pin_nine, slow_crystal_in, slow_rc_clk, fast_rc_clk, xtal_osc_clk};

    genvar gi;
    generate
        for (gi = 0; gi < sscs_pkg::NPIN; gi++)
        begin : g_sync
            always_comb
            begin
                filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
                rise[gi] = filt_next[gi] & ~filt_reg[gi];
            end
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    s1_reg[gi] <= 1'b0;
                    s2_reg[gi] <= 1'b0;
                    s3_reg[gi] <= 1'b0;
                    filt_reg[gi] <= 1'b0;
                end
                else
                begin
                    s1_reg[gi] <= pin_raw[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    filt_reg[gi] <= filt_next[gi];
                end
            end
        end
    endgenerate

    // ==========================================
    // register slave
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [sscs_pkg::ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] mode_reg, mode_next;
    logic [2:0] div_reg, div_next;
    logic [sscs_pkg::SLEEP_LEN_W-1:0] sleep_len_reg, sleep_len_next;
    logic [sscs_pkg::CAL_W-1:0] cal_reg, cal_next;
    logic wr_fire, sw_req, sleep_go, slow_wr;
    logic [31:0] wmask, ctrl_view, status_view, merged;
    logic [sscs_pkg::ADDR_W-1:0] ar_word, aw_word;

    // core state declared here for the status view
    logic sys_src_reg, sys_src_next, phase_reg, phase_next, pend_reg, pend_next;
    logic asleep_reg, asleep_next, lock_reg, lock_next;
    logic [1:0] slow_src_reg, slow_src_next;
    logic [sscs_pkg::RC_CNT_W-1:0] rc_cnt_reg, rc_cnt_next;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
            m[i*8 +: 8] = {8{s[i]}};
        return m;
    endfunction

    assign awready = !aw_have_reg && !bvalid_reg;
    assign wready = !w_have_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    always_comb
    begin
        ctrl_view = '0;
        ctrl_view[sscs_pkg::CTRL_MODE_LSB +: 2] = mode_reg;
        ctrl_view[sscs_pkg::CTRL_DIV_LSB +: 3] = div_reg;
        status_view = '0;
        status_view[sscs_pkg::STAT_SRC_BIT] = sys_src_reg;
        status_view[sscs_pkg::STAT_XRDY_BIT] = filt_reg[sscs_pkg::PIN_XRDY];
        status_view[sscs_pkg::STAT_SLOW_LSB +: 2] = slow_src_reg;
        status_view[sscs_pkg::STAT_LOCK_BIT] = lock_reg;
        status_view[sscs_pkg::STAT_RCRUN_BIT] = (32'(rc_cnt_reg) < SLOW_RC_TIMEOUT_CYC);
        status_view[sscs_pkg::STAT_ASLEEP_BIT] = asleep_reg;
        status_view[sscs_pkg::STAT_PEND_BIT] = pend_reg;
        aw_word = {aw_addr_reg[sscs_pkg::ADDR_W-1:2], 2'b00};
        ar_word = {araddr[sscs_pkg::ADDR_W-1:2], 2'b00};
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next = w_have_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        mode_next = mode_reg;
        div_next = div_reg;
        sleep_len_next = sleep_len_reg;
        cal_next = cal_reg;
        sw_req = 1'b0;
        sleep_go = 1'b0;
        slow_wr = 1'b0;
        wmask = strb_mask(w_strb_reg);
        merged = w_data_reg & wmask;
        wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
        if (awvalid && awready)
        begin
            aw_have_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (wvalid && wready)
        begin
            w_have_next = 1'b1;
            w_data_next = wdata;
            w_strb_next = wstrb;
        end
        if (bvalid_reg && bready)
            bvalid_next = 1'b0;
        if (wr_fire)
        begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = sscs_pkg::RESP_OKAY;
            case (aw_word)
                sscs_pkg::ADDR_CTRL:
                begin
                    merged = (ctrl_view & ~wmask) | (w_data_reg & wmask);
                    mode_next = merged[sscs_pkg::CTRL_MODE_LSB +: 2];
                    if (merged[sscs_pkg::CTRL_DIV_LSB +: 3] <= sscs_pkg::CPU_1)
                        div_next = merged[sscs_pkg::CTRL_DIV_LSB +: 3];
                    sw_req = merged[sscs_pkg::CTRL_SWITCH_BIT];
                    sleep_go = merged[sscs_pkg::CTRL_SLEEP_BIT];
                end
                sscs_pkg::ADDR_SLOW_SEL:
                    slow_wr = w_strb_reg[0];
                sscs_pkg::ADDR_STATUS:
                    bresp_next = sscs_pkg::RESP_OKAY;
                sscs_pkg::ADDR_SLEEP_LEN:
                    sleep_len_next = sscs_pkg::SLEEP_LEN_W'((32'(sleep_len_reg) & ~wmask) | merged);
                sscs_pkg::ADDR_CAL:
                    cal_next = sscs_pkg::CAL_W'((32'(cal_reg) & ~wmask) | merged);
                default:
                    bresp_next = sscs_pkg::RESP_SLVERR;
            endcase
        end
        if (rvalid_reg && rready)
            rvalid_next = 1'b0;
        if (arvalid && arready)
        begin
            rvalid_next = 1'b1;
            rresp_next = sscs_pkg::RESP_OKAY;
            case (ar_word)
                sscs_pkg::ADDR_CTRL: rdata_next = ctrl_view;
                sscs_pkg::ADDR_SLOW_SEL: rdata_next = 32'(slow_src_reg);
                sscs_pkg::ADDR_STATUS: rdata_next = status_view;
                sscs_pkg::ADDR_SLEEP_LEN: rdata_next = 32'(sleep_len_reg);
                sscs_pkg::ADDR_CAL: rdata_next = 32'(cal_reg);
                default:
                begin
                    rdata_next = '0;
                    rresp_next = sscs_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_have_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= sscs_pkg::RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= sscs_pkg::RESP_OKAY;
            mode_reg <= sscs_pkg::RST_MODE;
            div_reg <= sscs_pkg::RST_DIV;
            sleep_len_reg <= sscs_pkg::RST_SLEEP_LEN;
            cal_reg <= sscs_pkg::CAL_ONE;
        end
        else
        begin
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg <= w_have_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            mode_reg <= mode_next;
            div_reg <= div_next;
            sleep_len_reg <= sleep_len_next;
            cal_reg <= cal_next;
        end
    end

    // ==========================================
    // clock generation, source switching, slow clock and sleep timer
    logic sys_en_reg, sys_en_next, cpu_en_reg, cpu_en_next, slow_tick_reg, slow_tick_next;
    logic wake_reg, wake_next, osc_edge, slow_edge, cpu_tick, xrdy;
    logic [2:0] div_act_reg, div_act_next;
    logic [sscs_pkg::CPU_CNT_W-1:0] cpu_cnt_reg, cpu_cnt_next, cpu_mask;
    logic [sscs_pkg::ACC_W-1:0] acc_reg, acc_next, acc_sum, acc_target;
    logic [sscs_pkg::CAL_W-1:0] step;

    always_comb
    begin
        xrdy = filt_reg[sscs_pkg::PIN_XRDY];
        osc_edge = !asleep_reg && (sys_src_reg ? rise[sscs_pkg::PIN_XTAL] : rise[sscs_pkg::PIN_FRC]);
        sys_src_next = sys_src_reg;
        phase_next = phase_reg;
        pend_next = pend_reg;
        asleep_next = asleep_reg;
        sys_en_next = 1'b0;
        wake_next = 1'b0;
        acc_next = acc_reg;
        if (osc_edge)
        begin
            phase_next = ~phase_reg;
            sys_en_next = phase_reg;
        end
        if (mode_reg == sscs_pkg::SW_MANUAL && sw_req)
            pend_next = 1'b1;
        if (mode_reg == sscs_pkg::SW_AUTO && !sys_src_reg && xrdy && !asleep_reg)
            pend_next = 1'b1;
        if (mode_reg != sscs_pkg::SW_AUTO && mode_reg != sscs_pkg::SW_MANUAL)
            pend_next = 1'b0;
        // switch only at a whole period
        if (pend_reg && !sys_src_reg && xrdy && !phase_reg && !osc_edge && !asleep_reg && !sys_en_reg)
        begin
            sys_src_next = 1'b1;
            pend_next = 1'b0;
        end
        case (slow_src_reg)
            sscs_pkg::SLOW_XTAL: slow_edge = rise[sscs_pkg::PIN_SXT];
            sscs_pkg::SLOW_EXT: slow_edge = rise[sscs_pkg::PIN_SEXT];
            default: slow_edge = rise[sscs_pkg::PIN_SRC];
        endcase
        slow_tick_next = slow_edge;
        slow_src_next = slow_src_reg;
        lock_next = lock_reg;
        if (slow_wr && !lock_reg && (w_data_reg[sscs_pkg::SLOW_SEL_LSB +: 2] == sscs_pkg::SLOW_XTAL ||
                                     w_data_reg[sscs_pkg::SLOW_SEL_LSB +: 2] == sscs_pkg::SLOW_EXT))
        begin
            slow_src_next = w_data_reg[sscs_pkg::SLOW_SEL_LSB +: 2];
            lock_next = 1'b1;
        end
        rc_cnt_next = rc_cnt_reg;
        if (rise[sscs_pkg::PIN_SRC])
            rc_cnt_next = '0;
        else if (32'(rc_cnt_reg) < SLOW_RC_TIMEOUT_CYC)
            rc_cnt_next = rc_cnt_reg + 1'b1;
        step = (slow_src_reg == sscs_pkg::SLOW_RC) ? cal_reg : sscs_pkg::CAL_ONE;
        acc_sum = acc_reg + sscs_pkg::ACC_W'(step);
        acc_target = sscs_pkg::ACC_W'(sleep_len_reg) << sscs_pkg::CAL_FRAC_BITS;
        if (sleep_go && !asleep_reg)
        begin
            asleep_next = 1'b1;
            acc_next = '0;
            sys_en_next = 1'b0;
            phase_next = 1'b0;
            pend_next = 1'b0;
        end
        else if (asleep_reg && slow_edge)
        begin
            acc_next = acc_sum;
            if (acc_sum >= acc_target)
            begin
                asleep_next = 1'b0;
                wake_next = 1'b1;
                sys_src_next = 1'b0;
                acc_next = '0;
            end
        end
        cpu_mask = sscs_pkg::CPU_CNT_W'((5'h01 << div_act_reg) >> 1) - 1'b1;
        if (div_act_reg == sscs_pkg::CPU_32)
            cpu_tick = osc_edge;
        else
            cpu_tick = sys_en_next && ((cpu_cnt_reg & cpu_mask) == cpu_mask);
        cpu_cnt_next = sys_en_next ? cpu_cnt_reg + 1'b1 : cpu_cnt_reg;
        div_act_next = div_act_reg;
        if (cpu_tick)
        begin
            cpu_cnt_next = '0;
            if (div_act_reg != sscs_pkg::CPU_32 || sys_en_next)
                div_act_next = div_reg;
        end
        cpu_en_next = cpu_tick && !sleep_go;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sys_src_reg <= 1'b0;
            phase_reg <= 1'b0;
            pend_reg <= 1'b0;
            asleep_reg <= 1'b0;
            sys_en_reg <= 1'b0;
            cpu_en_reg <= 1'b0;
            cpu_cnt_reg <= '0;
            div_act_reg <= sscs_pkg::RST_DIV;
            slow_src_reg <= sscs_pkg::SLOW_RC;
            lock_reg <= 1'b0;
            slow_tick_reg <= 1'b0;
            rc_cnt_reg <= '0;
            acc_reg <= '0;
            wake_reg <= 1'b0;
        end
        else
        begin
            sys_src_reg <= sys_src_next;
            phase_reg <= phase_next;
            pend_reg <= pend_next;
            asleep_reg <= asleep_next;
            sys_en_reg <= sys_en_next;
            cpu_en_reg <= cpu_en_next;
            cpu_cnt_reg <= cpu_cnt_next;
            div_act_reg <= div_act_next;
            slow_src_reg <= slow_src_next;
            lock_reg <= lock_next;
            slow_tick_reg <= slow_tick_next;
            rc_cnt_reg <= rc_cnt_next;
            acc_reg <= acc_next;
            wake_reg <= wake_next;
        end
    end

    assign sys_clk_en = sys_en_reg;
    assign cpu_clk_en = cpu_en_reg;
    assign slow_tick = slow_tick_reg;
    assign sys_src_xtal = sys_src_reg;
    assign asleep = asleep_reg;
    assign wake_pulse = wake_reg;

    // ==========================================
    // assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_wake_rc;
        wake_pulse |-> !sys_src_xtal && !asleep;
    endproperty
    a_wake_rc: assert property (p_wake_rc) else $error("wake not on fast rc");
    property p_auto_sw;
        (mode_reg == sscs_pkg::SW_AUTO && !asleep && !sys_src_xtal && xrdy && !sleep_go) [*2]
            |-> ##[0:40] (sys_src_xtal || asleep || mode_reg != sscs_pkg::SW_AUTO || !xrdy);
    endproperty
    a_auto_sw: assert property (p_auto_sw) else $error("auto switch to crystal missing");
    property p_manual_hold;
        (mode_reg == sscs_pkg::SW_MANUAL && !pend_reg && !sys_src_xtal) |=> !sys_src_xtal;
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("manual mode left rc unrequested");
    property p_stay_rc;
        (mode_reg == sscs_pkg::SW_STAY_RC && !sys_src_xtal && !pend_reg) |=> !sys_src_xtal;
    endproperty
    a_stay_rc: assert property (p_stay_rc) else $error("stay-rc mode left rc");
    property p_slow_lock;
        lock_reg |=> lock_reg && $stable(slow_src_reg);
    endproperty
    a_slow_lock: assert property (p_slow_lock) else $error("locked slow source changed");
    property p_slow_free;
        !lock_reg |-> slow_src_reg == sscs_pkg::SLOW_RC;
    endproperty
    a_slow_free: assert property (p_slow_free) else $error("slow source not rc before lock");
    property p_no_short;
        sys_clk_en |=> !sys_clk_en [*8];
    endproperty
    a_no_short: assert property (p_no_short) else $error("system clock pulse too close");
    property p_sw_boundary;
        $rose(sys_src_xtal) |-> !$past(phase_reg) && !$past(sys_clk_en);
    endproperty
    a_sw_boundary: assert property (p_sw_boundary) else $error("switch mid period");
    property p_sleep_gate;
        asleep |-> !sys_clk_en && !cpu_clk_en;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("clock during sleep");
    property p_cpu_sync;
        (cpu_clk_en && $past(div_act_reg) != sscs_pkg::CPU_32) |-> sys_clk_en;
    endproperty
    a_cpu_sync: assert property (p_cpu_sync) else $error("cpu tick off system tick");
    property p_cal_step;
        (asleep_reg && slow_edge && !wake_next && slow_src_reg == sscs_pkg::SLOW_RC && !sleep_go)
            |=> acc_reg == $past(acc_reg) + sscs_pkg::ACC_W'($past(cal_reg));
    endproperty
    a_cal_step: assert property (p_cal_step) else $error("calibration step wrong");

    c_to_xtal: cover property ($rose(sys_src_xtal));
    c_wake: cover property (wake_pulse);
    c_lock: cover property ($rose(lock_reg));
    c_sleep: cover property ($rose(asleep));

endmodule

// *** bench/sscs_osc_model.sv ***
// oscillator and external slow clock model for the clock selector bench
module sscs_osc_model (
    output logic xtal_osc_clk,
    output logic fast_rc_clk,
    output logic slow_rc_clk,
    output logic slow_crystal_in,
    output logic gpio_pin_nine,
    output logic xtal_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // fast sources
    // crystal at 32 MHz, fast rc at 27 MHz
    initial xtal_osc_clk = 1'b0;
    always #15.625 xtal_osc_clk = ~xtal_osc_clk;
    initial fast_rc_clk = 1'b0;
    always #18.5 fast_rc_clk = ~fast_rc_clk;
    // free running slow sources, scaled up for short runs
    initial slow_rc_clk = 1'b0;
    always #100 slow_rc_clk = ~slow_rc_clk;
    initial slow_crystal_in = 1'b0;
    always #130 slow_crystal_in = ~slow_crystal_in;
    initial gpio_pin_nine = 1'b0;
    always #160 gpio_pin_nine = ~gpio_pin_nine;
    // crystal start-up delay
    initial
    begin
        xtal_ready = 1'b0;
        #2000 xtal_ready = 1'b1;
    end
endmodule

// *** bench/sscs_clock_select_test.sv ***
// self-checking bench for the clock source selector
module sscs_clock_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, awready, wready, bvalid, arready, rvalid, sys_clk_en, cpu_clk_en, slow_tick, sys_src_xtal, asleep;
    logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [sscs_pkg::ADDR_W-1:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, rs, ev;
    logic xtal_osc_clk, fast_rc_clk, slow_rc_clk, slow_crystal_in, gpio_pin_nine, xtal_ready, wake_pulse;
    int n_fail = 0, comparisons = 0, n_sys = 0, n_cpu = 0, n_slow = 0, s, c, t, i;
    logic [38:0] rows [5] = '{{sscs_pkg::RESP_OKAY, sscs_pkg::ADDR_CTRL, 32'h8},
        {sscs_pkg::RESP_OKAY, sscs_pkg::ADDR_SLOW_SEL, 32'h0}, {sscs_pkg::RESP_OKAY, sscs_pkg::ADDR_SLEEP_LEN, 32'h20},
        {sscs_pkg::RESP_OKAY, sscs_pkg::ADDR_CAL, 32'h100}, {sscs_pkg::RESP_SLVERR, 5'h14, 32'h0}};
    assign ev = {wake_pulse, sys_src_xtal};
    sscs_osc_model sscs_osc_model_inst (.xtal_osc_clk, .fast_rc_clk, .slow_rc_clk, .slow_crystal_in, .gpio_pin_nine,
        .xtal_ready);
    sscs_clock_select #(.SLOW_RC_TIMEOUT_CYC(200)) sscs_clock_select_inst (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .xtal_osc_clk, .fast_rc_clk, .slow_rc_clk, .slow_crystal_in, .gpio_pin_nine,
        .xtal_ready, .sys_clk_en, .cpu_clk_en, .slow_tick, .sys_src_xtal, .asleep, .wake_pulse);
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        n_sys <= n_sys + int'(sys_clk_en);
        n_cpu <= n_cpu + int'(cpu_clk_en);
        n_slow <= n_slow + int'(slow_tick);
    end
    // ==========================================
    // helpers
    task automatic end_of_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic lim(input int k, n);
        if (k == n)
        begin
            n_fail++;
            $display("Error at %0t: wait timed out", $time);
            end_of_test();
        end
    endtask
    task automatic rng(input int v, lo, hi);
        chk(32'(v >= lo && v <= hi), 32'h1);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 30; i++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        rs = bresp;
        bready <= 1'b0;
        lim(i, 30);
    endtask
    task automatic rdr(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 30; i++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        lim(i, 30);
    endtask
    task automatic wt(input int b, n);
        for (i = 0; i < n; i++)
        begin
            @(posedge aclk);
            if (ev[b] === 1'b1)
                break;
        end
        lim(i, n);
    endtask
    task automatic meas(input int n);
        s = n_sys;
        c = n_cpu;
        t = n_slow;
        repeat (n) @(posedge aclk);
        s = n_sys - s;
        c = n_cpu - c;
        t = n_slow - t;
    endtask
    task automatic nap(input logic [31:0] v);
        int t0;
        t0 = n_slow;
        wr(sscs_pkg::ADDR_CTRL, v);
        @(posedge aclk);
        chk(asleep, 1'b1);
        meas(10);
        chk(s, 0);
        wt(1, 3000);
        chk(sys_src_xtal, 1'b0);
        @(posedge aclk);
        t = n_slow - t0;
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[k])
        begin
            rdr(rows[k][36:32]);
            chk(rd, rows[k][31:0]);
            chk(rs, rows[k][38:37]);
        end
        chk(sys_src_xtal, 1'b0);
        meas(250);
        rng(s, 13, 14);
        rdr(sscs_pkg::ADDR_STATUS);
        chk(rd[5:2], 4'h8);
        wt(0, 1000);
        rdr(sscs_pkg::ADDR_STATUS);
        chk(rd[0], 1'b1);
        meas(250);
        rng(s, 15, 17);
        for (int d = 0; d < 6; d++)
        begin
            wr(sscs_pkg::ADDR_CTRL, 32'(d << 3));
            repeat (300) @(posedge aclk);
            meas(500);
            rng(c, (64 >> d) - 1, (64 >> d) + 1);
        end
        wr(sscs_pkg::ADDR_SLEEP_LEN, 32'h4);
        wr(sscs_pkg::ADDR_CAL, 32'h200);
        nap(32'h48);
        rng(t, 2, 3);
        wt(0, 1000);
        nap(32'h49);
        repeat (200) @(posedge aclk);
        chk(sys_src_xtal, 1'b0);
        wr(sscs_pkg::ADDR_CTRL, 32'h0d);
        wt(0, 200);
        nap(32'h4a);
        wr(sscs_pkg::ADDR_CTRL, 32'h0e);
        repeat (300) @(posedge aclk);
        chk(sys_src_xtal, 1'b0);
        wr(sscs_pkg::ADDR_SLOW_SEL, 32'h2);
        chk(rs, sscs_pkg::RESP_OKAY);
        wr(sscs_pkg::ADDR_SLOW_SEL, 32'h1);
        rdr(sscs_pkg::ADDR_STATUS);
        chk(rd[4:2], 3'h6);
        meas(1000);
        rng(t, 12, 13);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(sscs_pkg::ADDR_STATUS);
        chk(rd[4:2], 3'h0);
        wr(sscs_pkg::ADDR_SLOW_SEL, 32'h1);
        meas(1000);
        rng(t, 15, 16);
        end_of_test();
    end
endmodule
